/* File: verilog/uifp_pkg.sv */
/*
 Constants, encodings and state type of the universal input
 frequency/PWM/discrete channel. Assumes a 25 MHz system clock.
*/
// What this block does
// - Discrete mode samples the input once every millisecond.
// - Zero debounce passes samples; else level changes after stable configured time.
// - Frequency and duty come from counting internal clock ticks per input period.
// - Each channel owns a 16-bit period counter, range 0.9155 Hz to 12.5 kHz.
// - Polarity picks the edge: active-high rising, active-low falling.
// - Enabled spike filter suppresses pulses shorter than the selected time.
// - Optional moving average over recent readings before output.
// - Frequency below minimum, DC included, reports zero.
// - Reported frequency is clamped to the maximum frequency.
// - Above maximum enters Recovery until next counter saturation re-measures.
// - Recovery is left only if measured frequency at saturation is below maximum.
// - Recovery lasts at least one saturation interval; frequency stays at maximum meanwhile.
// - Absent PWM reports 0% or 100% from level and polarity at saturation.
// - After PWM vanishes the last duty holds until DC duty takes over.
// - PWM below minimum reports 0% or 100% from level at saturation.
// - PWM above maximum enters Recovery and reports 0% duty.
// - Filter setting: 0 off, 1 142 ns, 2 1.14 us, 3 6.10 us.
// - Averaging setting: 0 none, 1 three, 2 five, 3 ten readings.
// - Polarity setting: 0 active-high, 1 active-low.
`default_nettype none
package uifp_pkg;
    localparam int CLK_HZ           = 25_000_000;
    localparam int CLK_PERIOD_NS    = 40;
    localparam int SAMPLE_PERIOD_US = 1000;
    localparam int MS_CYC           = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int FLT1_NS          = 142;
    localparam int FLT2_NS          = 1140;
    localparam int FLT3_NS          = 6100;
    localparam int FLT1_CYC         = (FLT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLT2_CYC         = (FLT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLT3_CYC         = (FLT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    // Tick rate: minimum frequency 0.9155 Hz times 2^16
    localparam int F_TICK_HZ        = 60000;
    localparam int TICK_DIV         = CLK_HZ / F_TICK_HZ;
    localparam int FREQ_MAX_HZ      = 12500;
    localparam logic [15:0] FREQ_MAX      = 16'(FREQ_MAX_HZ);
    localparam logic [15:0] MIN_CNT       = 16'((F_TICK_HZ + FREQ_MAX_HZ - 1) / FREQ_MAX_HZ);
    localparam logic [15:0] REC_EDGES_MAX = 16'(FREQ_MAX_HZ * (int'(CNT_MAX) + 1) / F_TICK_HZ);
    localparam logic [6:0]  DUTY_FULL     = 7'h64;
    localparam logic [6:0]  DUTY_ZERO     = 7'h00;
    localparam logic        POL_HIGH      = 1'b0;
    localparam logic [1:0]  SEL_0         = 2'h0;
    localparam logic [1:0]  SEL_1         = 2'h1;
    localparam logic [1:0]  SEL_2         = 2'h2;
    localparam logic [1:0]  SEL_3         = 2'h3;
    localparam int          AVG_MAX       = 10;
    localparam logic [3:0]  AVG_N0        = 4'h1;
    localparam logic [3:0]  AVG_N1        = 4'h3;
    localparam logic [3:0]  AVG_N2        = 4'h5;
    localparam logic [3:0]  AVG_N3        = 4'hA;
    localparam int          DIV_W         = 32;
    // Cycles until synchroniser and filter hold the pin level
    localparam logic [2:0]  SETTLE_CYC    = 3'h4;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_FREQ = 5'h02,
        S_DUTY = 5'h04,
        S_AVGF = 5'h08,
        S_AVGD = 5'h10
    } uifp_st_t;
endpackage
`default_nettype wire

/* File: verilog/uifp_div_if.sv */
/*
 Request/answer bundle between the channel and its serial divider.
 Assumes both ends on the same clock; start and done are one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
interface uifp_div_if;
    logic        start;
    logic [31:0] num;
    logic [15:0] den;
    logic        done;
    logic [15:0] quo;
    modport req (output start, output num, output den, input done, input quo);
    modport srv (input start, input num, input den, output done, output quo);
endinterface
`default_nettype wire

/* File: verilog/uifp_div.sv */
/*
 Restoring serial divider, 32-bit by 16-bit, quotient saturated to 16 bits.
 Assumes start is not raised while a division runs.
*/
`timescale 1ns/1ps
`default_nettype none
module uifp_div
    import uifp_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic srst_i,
    uifp_div_if.srv   div
);
    typedef struct packed {
        logic        busy;
        logic [5:0]  cnt;
        logic [31:0] num;
        logic [15:0] den;
        logic [16:0] rem;
        logic [31:0] quo;
        logic        done;
    } uifp_div_st_t;

    uifp_div_st_t r;
    uifp_div_st_t n;
    logic [16:0]  rem_sh;

    assign rem_sh   = {r.rem[15:0], r.num[31]};
    assign div.done = r.done;
    assign div.quo  = (r.quo[31:16] != 16'h0000) ? 16'hFFFF : r.quo[15:0];

    always_comb
    begin
        n      = r;
        n.done = 1'b0;
        if (div.start)
        begin
            n.busy = 1'b1;
            n.cnt  = 6'h00;
            n.num  = div.num;
            n.den  = div.den;
            n.rem  = 17'h00000;
            n.quo  = 32'h00000000;
        end
        else if (r.busy)
        begin
            if (rem_sh >= {1'b0, r.den})
            begin
                n.rem = rem_sh - {1'b0, r.den};
                n.quo = {r.quo[30:0], 1'b1};
            end
            else
            begin
                n.rem = rem_sh;
                n.quo = {r.quo[30:0], 1'b0};
            end
            n.num = {r.num[30:0], 1'b0};
            n.cnt = r.cnt + 6'h01;
            if (r.cnt == 6'(DIV_W - 1))
            begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            r <= '0;
        else
            r <= n;
    end

    a_div_latency: assert property (@(posedge clk_i) disable iff (srst_i)
        div.start |-> ##33 div.done) else $error("divider answer not 33 cycles after start");
endmodule
`default_nettype wire

/* File: verilog/uifp_chan.sv */
/*
 One universal input channel: discrete level, period counting for
 frequency and PWM duty, spike filter, Recovery and averaging.
 Assumes sig_i is asynchronous to clk_i and settings are quasi-static.
*/
`timescale 1ns/1ps
`default_nettype none
module uifp_chan
    import uifp_pkg::*;
#(
    parameter int MS_CYC_P   = MS_CYC,
    parameter int TICK_DIV_P = TICK_DIV
)(
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       sig_i,
    input  wire logic       polarity_i,
    input  wire logic [1:0] filt_sel_i,
    input  wire logic [1:0] avg_sel_i,
    input  wire logic [9:0] disc_deb_ms_i,
    output logic            disc_level_o,
    output logic [15:0]     freq_o,
    output logic [6:0]      duty_o,
    output logic            recovery_o,
    output logic            valid_o,
    output logic            sat_evt_o
);
    typedef struct packed {
        logic [1:0]                sync;
        logic                      filt;
        logic [7:0]                fcnt;
        logic                      act_d;
        logic [8:0]                psc;
        logic [15:0]               per_cnt;
        logic [15:0]               act_cnt;
        logic                      seen;
        logic                      rec;
        logic [15:0]               edges;
        logic [15:0]               cap_per;
        logic [15:0]               cap_act;
        uifp_st_t                  st;
        logic                      go;
        logic [15:0]               f_new;
        logic [AVG_MAX-1:0][15:0]  hist_f;
        logic [AVG_MAX-1:0][15:0]  hist_d;
        logic [3:0]                fill;
        logic [15:0]               freq;
        logic [6:0]                duty;
        logic                      valid;
        logic                      sat;
        logic [14:0]               ms_cnt;
        logic                      disc;
        logic [9:0]                deb_cnt;
        logic [2:0]                settle;
    } uifp_chan_t;

    uifp_chan_t  r;
    uifp_chan_t  n;
    logic        act;
    logic        edge_a;
    logic        armed;
    logic        restart;
    logic        tick;
    logic        sat_now;
    logic        ms_tick;
    logic        smp;
    logic [6:0]  sat_duty;
    logic [7:0]  flt_cyc;
    logic [3:0]  n_avg;
    logic [3:0]  n_eff;
    logic [19:0] sum_f;
    logic [19:0] sum_d;

    uifp_div_if div ();

    uifp_div u_div (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .div    (div.srv)
    );

    // Active level follows polarity: rising edge of act is the period edge
    assign act      = r.filt ^ (polarity_i != POL_HIGH);
    // No edge until sync and filter hold the pin level: no false edge after reset
    assign armed    = (r.settle == SETTLE_CYC);
    assign edge_a   = act & ~r.act_d & armed;
    assign restart  = edge_a & ~r.rec;
    assign tick     = (r.psc == 9'(TICK_DIV_P - 1));
    assign sat_now  = tick && (r.per_cnt == CNT_MAX) && !restart;
    assign ms_tick  = (r.ms_cnt == 15'(MS_CYC_P - 1));
    assign smp      = r.sync[1] ^ (polarity_i != POL_HIGH);
    assign sat_duty = act ? DUTY_FULL : DUTY_ZERO;

    always_comb
    begin
        case (filt_sel_i)
            SEL_1:   flt_cyc = 8'(FLT1_CYC);
            SEL_2:   flt_cyc = 8'(FLT2_CYC);
            SEL_3:   flt_cyc = 8'(FLT3_CYC);
            default: flt_cyc = 8'h01;
        endcase
        case (avg_sel_i)
            SEL_1:   n_avg = AVG_N1;
            SEL_2:   n_avg = AVG_N2;
            SEL_3:   n_avg = AVG_N3;
            default: n_avg = AVG_N0;
        endcase
        n_eff = (r.fill < n_avg) ? r.fill : n_avg;
        sum_f = 20'h00000;
        sum_d = 20'h00000;
        for (int i = 0; i < AVG_MAX; i++)
        begin
            if (4'(i) < n_eff)
            begin
                sum_f = sum_f + 20'(r.hist_f[i]);
                sum_d = sum_d + 20'(r.hist_d[i]);
            end
        end
    end

    // Divider operands per step of the measurement chain
    assign div.start = r.go;
    always_comb
    begin
        div.num = 32'h00000000;
        div.den = 16'h0000;
        case (r.st)
            S_FREQ:
            begin
                div.num = 32'(F_TICK_HZ);
                div.den = r.cap_per;
            end
            S_DUTY:
            begin
                div.num = 32'(r.cap_act) * 32'(DUTY_FULL);
                div.den = r.cap_per;
            end
            S_AVGF:
            begin
                div.num = 32'(sum_f);
                div.den = 16'(n_eff);
            end
            S_AVGD:
            begin
                div.num = 32'(sum_d);
                div.den = 16'(n_eff);
            end
            default:
            begin
                div.num = 32'h00000000;
                div.den = 16'h0000;
            end
        endcase
    end

    always_comb
    begin
        n       = r;
        n.valid = 1'b0;
        n.sat   = 1'b0;
        n.go    = 1'b0;
        n.sync  = {r.sync[0], sig_i};
        n.act_d = act;
        if (!armed)
            n.settle = r.settle + 3'h1;
        // Spike filter on the synchronised input, bypassed while settling
        if (filt_sel_i == SEL_0 || !armed)
        begin
            n.filt = r.sync[1];
            n.fcnt = 8'h00;
        end
        else if (r.sync[1] == r.filt)
            n.fcnt = 8'h00;
        else if (r.fcnt + 8'h01 >= flt_cyc)
        begin
            n.filt = r.sync[1];
            n.fcnt = 8'h00;
        end
        else
            n.fcnt = r.fcnt + 8'h01;
        n.psc = tick ? 9'h000 : r.psc + 9'h001;
        // Edges in Recovery only counted over the saturation window
        if (edge_a && r.rec && r.edges != CNT_MAX)
            n.edges = r.edges + 16'h0001;
        if (restart)
        begin
            // Tick on the edge cycle belongs to the new period
            n.per_cnt = {15'h0000, tick};
            n.act_cnt = {15'h0000, tick & act};
            n.seen    = 1'b1;
            if (r.seen && r.st == S_IDLE)
            begin
                n.cap_per = r.per_cnt;
                n.cap_act = r.act_cnt;
                if (r.per_cnt < MIN_CNT)
                begin
                    n.rec   = 1'b1;
                    n.edges = 16'h0000;
                    n.freq  = FREQ_MAX;
                    n.duty  = DUTY_ZERO;
                    n.valid = 1'b1;
                    n.fill  = 4'h0;
                end
                else
                begin
                    n.st = S_FREQ;
                    n.go = 1'b1;
                end
            end
        end
        else if (tick)
        begin
            if (r.per_cnt == CNT_MAX)
            begin
                n.per_cnt = 16'h0000;
                n.act_cnt = 16'h0000;
                n.seen    = 1'b0;
                n.sat     = 1'b1;
                n.edges   = 16'h0000;
                if (r.rec)
                begin
                    if (r.edges <= REC_EDGES_MAX)
                        n.rec = 1'b0;
                end
                else
                begin
                    n.freq  = 16'h0000;
                    n.duty  = sat_duty;
                    n.valid = 1'b1;
                    n.fill  = 4'h0;
                end
            end
            else
            begin
                n.per_cnt = r.per_cnt + 16'h0001;
                n.act_cnt = r.act_cnt + {15'h0000, act};
            end
        end
        case (r.st)
            S_IDLE:
                n.st = n.st;
            S_FREQ:
                if (div.done)
                begin
                    n.f_new = (div.quo > FREQ_MAX) ? FREQ_MAX : div.quo;
                    n.st    = S_DUTY;
                    n.go    = 1'b1;
                end
            S_DUTY:
                if (div.done)
                begin
                    n.hist_f = {r.hist_f[AVG_MAX-2:0], r.f_new};
                    n.hist_d = {r.hist_d[AVG_MAX-2:0],
                                (div.quo > 16'(DUTY_FULL)) ? 16'(DUTY_FULL) : div.quo};
                    if (r.fill < 4'(AVG_MAX))
                        n.fill = r.fill + 4'h1;
                    n.st = S_AVGF;
                    n.go = 1'b1;
                end
            S_AVGF:
                if (div.done)
                begin
                    n.freq = div.quo;
                    n.st   = S_AVGD;
                    n.go   = 1'b1;
                end
            S_AVGD:
                if (div.done)
                begin
                    n.duty  = div.quo[6:0];
                    n.valid = 1'b1;
                    n.st    = S_IDLE;
                end
            default:
                n.st = S_IDLE;
        endcase
        // Discrete level, sampled once per millisecond
        n.ms_cnt = ms_tick ? 15'h0000 : r.ms_cnt + 15'h0001;
        if (ms_tick)
        begin
            if (disc_deb_ms_i == 10'h000)
            begin
                n.disc    = smp;
                n.deb_cnt = 10'h000;
            end
            else if (smp == r.disc)
                n.deb_cnt = 10'h000;
            else if (r.deb_cnt + 10'h001 >= disc_deb_ms_i)
            begin
                n.disc    = smp;
                n.deb_cnt = 10'h000;
            end
            else
                n.deb_cnt = r.deb_cnt + 10'h001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            r    <= '0;
            r.st <= S_IDLE;
        end
        else
            r <= n;
    end

    assign disc_level_o = r.disc;
    assign freq_o       = r.freq;
    assign duty_o       = r.duty;
    assign recovery_o   = r.rec;
    assign valid_o      = r.valid;
    assign sat_evt_o    = r.sat;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    a_ms_sample: assert property ($changed(disc_level_o) |-> $past(ms_tick))
        else $error("discrete level changed off the 1 ms sample");
    a_disc_pass: assert property ((ms_tick && disc_deb_ms_i == 10'h000) |=>
        (disc_level_o == $past(smp))) else $error("undebounced sample not passed");
    a_flt_spike: assert property (($changed(r.filt) && filt_sel_i == SEL_1
        && $past(filt_sel_i, 4) == SEL_1 && $past(armed, 4)) |-> ($past(r.sync[1]) == r.filt
        && $past(r.sync[1], 4) == r.filt)) else $error("short spike passed the filter");
    a_sat_dc: assert property ((sat_now && !r.rec) |=> (freq_o == 16'h0000
        && duty_o == $past(sat_duty))) else $error("saturation result wrong");
    a_freq_clamp: assert property (freq_o <= FREQ_MAX)
        else $error("frequency above maximum");
    a_rec_entry: assert property ((restart && r.seen && r.st == S_IDLE
        && r.per_cnt < MIN_CNT) |=> (recovery_o && freq_o == FREQ_MAX
        && duty_o == DUTY_ZERO)) else $error("recovery entry wrong");
    a_rec_hold: assert property (recovery_o |-> freq_o == FREQ_MAX)
        else $error("frequency left maximum during recovery");
    a_rec_exit: assert property ($fell(recovery_o) |-> ($past(sat_now)
        && $past(r.edges) <= REC_EDGES_MAX)) else $error("recovery left off saturation");
    a_cnt_restart: assert property (sat_now |=> (r.per_cnt == 16'h0000 && !r.seen))
        else $error("counter not restarted after saturation");
    a_duty_range: assert property (duty_o <= DUTY_FULL)
        else $error("duty above 100");
    a_meas_chain: assert property ((restart && r.seen && r.st == S_IDLE
        && r.per_cnt >= MIN_CNT) |=> ##[120:150] valid_o) else $error("measurement not delivered");

    c_rec_entry: cover property ($rose(recovery_o));
    c_rec_exit:  cover property ($fell(recovery_o));
    c_measured:  cover property (valid_o && r.st == S_IDLE && !recovery_o && freq_o != 16'h0000);
    c_sat:       cover property (sat_now && !r.rec);
endmodule
`default_nettype wire

/* File: tb/uifp_src_model.sv */
/*
 Signal source model for one universal input: square wave, optional spike.
 Assumes per_i and hi_i change only between periods or while stopped.
*/
`timescale 1ns/1ps
`default_nettype none
module uifp_src_model (
    input  wire logic        clk_i,
    input  wire logic        run_i,
    input  wire logic        dc_lvl_i,
    input  wire logic [15:0] per_i,
    input  wire logic [15:0] hi_i,
    input  wire logic [15:0] spk_i,
    output logic             sig_o
);
    logic [15:0] cnt_r = 16'h0000;
    logic [15:0] mid;
    assign mid = hi_i + ((per_i - hi_i) >> 1);
    // Period never longer than per_i: no sub-minimum waves
    always @(posedge clk_i)
    begin
        if (!run_i || cnt_r >= per_i - 16'h0001)
            cnt_r <= #1 16'h0000;
        else
            cnt_r <= #1 cnt_r + 16'h0001;
    end
    // Stopped source shows a plain DC level
    assign sig_o = run_i ? ((cnt_r < hi_i) || (spk_i != 16'h0000 && cnt_r >= mid && cnt_r < mid + spk_i))
                         : dc_lvl_i;
endmodule
`default_nettype wire

/* File: tb/uifp_chan_tb_top.sv */
/*
 Self-checking bench for the universal input channel.
 Assumes shortened ms and tick dividers; the pin is driven by the source model.
*/
`timescale 1ns/1ps
`default_nettype none
module uifp_chan_tb_top
    import uifp_pkg::*;
;
    localparam int TDIV = 4;
    localparam int MSC  = 20;
    logic        clk_i         = 1'b0;
    logic        srst_i        = 1'b1;
    logic        polarity_i    = 1'b0;
    logic [1:0]  filt_sel_i    = SEL_0;
    logic [1:0]  avg_sel_i     = SEL_0;
    logic [9:0]  disc_deb_ms_i = 10'h000;
    logic        run           = 1'b0;
    logic        dc_lvl        = 1'b0;
    logic [15:0] per           = 16'h0190;
    logic [15:0] hi            = 16'h0064;
    logic [15:0] spk           = 16'h0000;
    logic        sig;
    logic        disc_level_o;
    logic [15:0] freq_o;
    logic [6:0]  duty_o;
    logic        recovery_o;
    logic        valid_o;
    logic        sat_evt_o;
    int          n_fail        = 0;
    int          total_checks  = 0;
    int          cyc           = 0;

    always #20 clk_i = ~clk_i;

    uifp_src_model src (.clk_i(clk_i), .run_i(run), .dc_lvl_i(dc_lvl), .per_i(per), .hi_i(hi),
                        .spk_i(spk), .sig_o(sig));

    uifp_chan #(.MS_CYC_P(MSC), .TICK_DIV_P(TDIV)) dut (
        .clk_i(clk_i), .srst_i(srst_i), .sig_i(sig), .polarity_i(polarity_i), .filt_sel_i(filt_sel_i),
        .avg_sel_i(avg_sel_i), .disc_deb_ms_i(disc_deb_ms_i), .disc_level_o(disc_level_o),
        .freq_o(freq_o), .duty_o(duty_o), .recovery_o(recovery_o), .valid_o(valid_o),
        .sat_evt_o(sat_evt_o));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            end_sim();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_valid();
        int n;
        n = 0;
        do
        begin
            step(1);
            n++;
        end
        while (valid_o !== 1'b1 && n < 4000);
        check("valid_o", {31'h0, valid_o}, 32'h1);
    endtask

    task automatic reset_dut();
        run = 1'b0;
        srst_i = 1'b1;
        step(5);
        srst_i = 1'b0;
    endtask

    // Configure, reset, start the wave and drop the first result
    task automatic meas(input logic pol, input logic [1:0] flt, input logic [1:0] avg,
                        input int p, input int h, input int s);
        polarity_i = pol;
        filt_sel_i = flt;
        avg_sel_i = avg;
        per = 16'(p);
        hi = 16'(h);
        spk = 16'(s);
        reset_dut();
        run = 1'b1;
        wait_valid();
    endtask

    task automatic expect_res(input int p, input int act);
        wait_valid();
        check("freq_o", 32'(freq_o), 32'(F_TICK_HZ / (p / TDIV)));
        check("duty_o", 32'(duty_o), 32'(act * 100 / p));
    endtask

    task automatic t_discrete();
        disc_deb_ms_i = 10'h000;
        reset_dut();
        dc_lvl = 1'b1;
        step(3 * MSC);
        check("disc_level_o", {31'h0, disc_level_o}, 32'h1);
        polarity_i = 1'b1;
        step(3 * MSC);
        check("disc_level_o", {31'h0, disc_level_o}, 32'h0);
        polarity_i = 1'b0;
        disc_deb_ms_i = 10'h003;
        step(5 * MSC);
        dc_lvl = 1'b0;
        step(MSC);
        check("disc_level_o", {31'h0, disc_level_o}, 32'h1);
        step(6 * MSC);
        check("disc_level_o", {31'h0, disc_level_o}, 32'h0);
    endtask

    task automatic t_freq_high();
        for (int a = 0; a < 4; a++)
        begin
            meas(1'b0, SEL_0, 2'(a), 400, 100, 0);
            expect_res(400, 100);
            expect_res(400, 100);
        end
    endtask

    task automatic t_freq_low();
        meas(1'b1, SEL_0, SEL_0, 400, 100, 0);
        expect_res(400, 300);
    endtask

    task automatic t_average();
        meas(1'b0, SEL_0, SEL_1, 400, 100, 0);
        wait_valid();
        wait_valid();
        per = 16'h00C8;
        for (int i = 0; i < 3; i++)
        begin
            wait_valid();
            check("freq_o", 32'(freq_o), 32'(((2 - i) * 600 + (i + 1) * 1200) / 3));
            check("duty_o", 32'(duty_o), 32'(((2 - i) * 25 + (i + 1) * 50) / 3));
        end
    endtask

    task automatic t_recovery();
        int n;
        int m;
        meas(1'b0, SEL_0, SEL_0, 12, 6, 0);
        check("freq_o", 32'(freq_o), 32'(FREQ_MAX));
        check("duty_o", 32'(duty_o), 32'(DUTY_ZERO));
        check("recovery_o", {31'h0, recovery_o}, 32'h1);
        n = 0;
        m = 0;
        // 3000 cycles are far fewer ticks than one saturation interval
        repeat (3000)
        begin
            step(1);
            if (valid_o === 1'b1)
                n++;
            if (sat_evt_o !== 1'b0)
                m++;
        end
        check("valid_count", 32'(n), 32'h0);
        check("sat_count", 32'(m), 32'h0);
        check("freq_o", 32'(freq_o), 32'(FREQ_MAX));
        check("recovery_o", {31'h0, recovery_o}, 32'h1);
        run = 1'b0;
    endtask

    task automatic t_filter();
        int fc[3];
        fc = '{FLT1_CYC, FLT2_CYC, FLT3_CYC};
        for (int i = 0; i < 3; i++)
        begin
            meas(1'b0, 2'(i + 1), SEL_0, 800, 400, fc[i] / 2);
            expect_res(800, 400);
        end
    endtask

    initial
    begin
        reset_dut();
        t_discrete();
        t_freq_high();
        t_freq_low();
        t_average();
        t_recovery();
        t_filter();
        end_sim();
    end
endmodule
`default_nettype wire
